// [src/spi_status_defs.vh]
// Constants for the serial port status and data register block
// Functional notes
// - Set transfer done flag, bit 7, when a byte exchange ends.
// - Request an interrupt on a rising done flag while interrupts enabled.
// - Ignore data register writes while the done flag is set.
// - Set write collision flag, bit 6, on a collision; software clears it.
// - Set overrun flag, bit 5, when a byte arrives before the last is read.
// - While overrun is set, refuse new bytes into the receive buffer.
// - Set mode fault flag, bit 4, on a mode fault; software clears it.
// - Writing zero clears done, collision or fault flag; one leaves it.
// - Overrun flag clears only by a software write.
// - Status bit 3 is a writable select pin configuration bit.
// - Data write starts an exchange only as master; slave just loads it.
// - Data reads return the receive buffer, not the live shifter.
// - The data register is 8 bits, bits 7 to 0 carry the byte.
// - Interrupt enable bit 0 raises a request on done, fault, collision or overrun; the code raises it only for events whose mask bit is set.
// - Config bit and select output enable choose select pin usage.
// - While mode fault is set the system enable bit reads zero.
`ifndef SPI_STATUS_DEFS_VH
`define SPI_STATUS_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_CONTROL 8'hF3
`define IDX_STATUS 8'hF4
`define IDX_DATA 8'hF5
`define IDX_IRQ_EN 8'hF9
`define IDX_EVENT 8'hE8
`define IDX_EVMASK 8'hE9

// Status register fields
`define ST_DONE 7
`define ST_COLL 6
`define ST_OVR 5
`define ST_FAULT 4
`define ST_CFG 3

// Control register fields
`define CT_SELECT_OUTPUT_ENABLE 7
`define CT_ENABLE 6
`define CT_MASTER 4

// Extended interrupt enable field
`define IE_SERIAL 0

// Event and mask register fields
`define EV_W 4
`define EV_DONE 0
`define EV_FAULT 1
`define EV_COLL 2
`define EV_OVR 3

// Select pin usage, {config bit, select output enable}
`define SS_FAULT_IN 2'b00
`define SS_RESERVED 2'b01
`define SS_GPIO 2'b10
`define SS_DRIVEN 2'b11

`define BYTE_RESET 8'h00
`define BIT_COUNT 4'h8
`define HALF_DIV_DEFAULT 4

`endif

// [src/spi_byte_shifter.v]
// Serial byte shifter, clock phase 0 and polarity 0, master or slave
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_defs.vh"

module spi_byte_shifter #(
    parameter HALF_DIV = `HALF_DIV_DEFAULT
) (
    input wire clock, // System clock
    input wire rstn, // Asynchronous reset, active low
    input wire enable, // Port enabled
    input wire master, // Master mode
    input wire start, // Master start pulse
    input wire load, // Load transmit byte
    input wire [7:0] tx_byte, // Byte to send
    input wire sclk_in, // Serial clock pin
    input wire mosi_in, // Master out pin
    input wire miso_in, // Master in pin
    input wire ss_in, // Select pin, active low
    output wire ss_level, // Synchronised select level
    output wire busy, // Exchange in progress
    output reg done, // One-cycle end of byte
    output reg [7:0] rx_byte, // Last received byte
    output reg sclk_out, // Master serial clock
    output wire mosi_out, // Master data out
    output wire miso_out // Slave data out
);

    reg [3:0] meta_reg;
    reg [3:0] sync_reg;
    reg sclk_last_reg;
    reg [7:0] shift_reg;
    reg [7:0] rx_reg;
    reg [3:0] bits_reg;
    reg run_reg;
    reg [7:0] div_reg;
    wire sclk_s;
    wire mosi_s;
    wire miso_s;
    wire tick;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // Idle levels, select high and clock low: no false edge
            meta_reg <= 4'h8;
            sync_reg <= 4'h8;
        end else begin
            meta_reg <= {ss_in, miso_in, mosi_in, sclk_in};
            sync_reg <= meta_reg;
        end
    end

    assign sclk_s = sync_reg[0];
    assign mosi_s = sync_reg[1];
    assign miso_s = sync_reg[2];
    assign ss_level = sync_reg[3];
    assign tick = (div_reg == HALF_DIV[7:0] - 8'h01);
    assign mosi_out = shift_reg[7];
    assign miso_out = shift_reg[7];
    assign busy = master ? run_reg : (!ss_level && bits_reg != 4'h0);

    ////////////////////////////////////////////////////////////////////
    // Shifting for both modes
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sclk_last_reg <= 1'b0;
            shift_reg <= `BYTE_RESET;
            rx_reg <= `BYTE_RESET;
            rx_byte <= `BYTE_RESET;
            bits_reg <= 4'h0;
            run_reg <= 1'b0;
            div_reg <= 8'h00;
            sclk_out <= 1'b0;
            done <= 1'b0;
        end else begin
            sclk_last_reg <= sclk_s;
            done <= 1'b0;
            if (!enable) begin
                // Disable aborts any exchange
                run_reg <= 1'b0;
                bits_reg <= 4'h0;
                sclk_out <= 1'b0;
                div_reg <= 8'h00;
            end else if (master) begin
                if (start && !run_reg) begin
                    shift_reg <= tx_byte;
                    bits_reg <= 4'h0;
                    run_reg <= 1'b1;
                    div_reg <= 8'h00;
                    sclk_out <= 1'b0;
                end else if (run_reg) begin
                    div_reg <= tick ? 8'h00 : div_reg + 8'h01;
                    if (tick && !sclk_out) begin
                        sclk_out <= 1'b1;
                        rx_reg <= {rx_reg[6:0], miso_s};
                        bits_reg <= bits_reg + 4'h1;
                    end else if (tick) begin
                        sclk_out <= 1'b0;
                        if (bits_reg == `BIT_COUNT) begin
                            run_reg <= 1'b0;
                            bits_reg <= 4'h0;
                            rx_byte <= rx_reg;
                            done <= 1'b1;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        end
                    end
                end
            end else begin
                run_reg <= 1'b0;
                if (ss_level) begin
                    bits_reg <= 4'h0;
                    if (load) begin
                        shift_reg <= tx_byte;
                    end
                end else if (sclk_s && !sclk_last_reg) begin
                    rx_reg <= {rx_reg[6:0], mosi_s};
                    if (bits_reg == `BIT_COUNT - 4'h1) begin
                        bits_reg <= 4'h0;
                        rx_byte <= {rx_reg[6:0], mosi_s};
                        done <= 1'b1;
                    end else begin
                        bits_reg <= bits_reg + 4'h1;
                    end
                end else if (!sclk_s && sclk_last_reg) begin
                    shift_reg <= {shift_reg[6:0], 1'b0};
                end else if (load && bits_reg == 4'h0) begin
                    // Slave byte waits for the external master
                    shift_reg <= tx_byte;
                end
            end
        end
    end

endmodule
`default_nettype wire

// [src/spi_status_and_data_regs.v]
// Serial port status, data and control registers behind Wishbone
`timescale 1ns/1ps
`default_nettype none
`include "spi_status_defs.vh"

module spi_status_and_data_regs #(
    parameter ADDR_W = 10,
    parameter HALF_DIV = `HALF_DIV_DEFAULT
) (
    input wire clock, // System clock, 25 MHz
    input wire rstn, // Asynchronous reset, active low
    input wire cyc_i, // Wishbone cycle
    input wire stb_i, // Wishbone strobe
    input wire we_i, // Wishbone write enable
    input wire [ADDR_W-1:0] adr_i, // Wishbone byte address
    input wire [31:0] dat_i, // Wishbone write data
    input wire [3:0] sel_i, // Wishbone byte selects
    output reg [31:0] dat_o, // Wishbone read data
    output reg ack_o, // Wishbone acknowledge
    output wire irq, // Interrupt request, active high level
    input wire sclk_in, // Serial clock pin input
    output wire sclk_out, // Serial clock pin output
    output wire sclk_oe, // Serial clock pin drive enable
    input wire mosi_in, // Master out pin input
    output wire mosi_out, // Master out pin output
    output wire mosi_oe, // Master out pin drive enable
    input wire miso_in, // Master in pin input
    output wire miso_out, // Master in pin output
    output wire miso_oe, // Master in pin drive enable
    input wire ss_in_n, // Select pin input, active low
    output wire ss_out_n, // Select pin output, active low
    output wire ss_oe // Select pin drive enable
);

    function [7:0] reg_index;
        input [ADDR_W-1:0] adr;
        begin
            reg_index = adr[9:2];
        end
    endfunction

    // Sticky flag; a hardware set wins over a clear in the same cycle
    function flag_next;
        input set;
        input cur;
        input clr;
        begin
            flag_next = set || (cur && !clr);
        end
    endfunction

    reg select_output_enable_reg;
    reg enable_reg;
    reg master_reg;
    reg irq_en_reg;
    reg cfg_reg;
    reg done_reg;
    reg coll_reg;
    reg ovr_reg;
    reg fault_reg;
    reg unread_reg;
    reg [7:0] rx_buf_reg;
    reg [`EV_W-1:0] event_reg;
    reg [`EV_W-1:0] mask_reg;
    reg [7:0] rd_next;
    reg [`EV_W-1:0] event_next;
    wire access;
    wire wr;
    wire rd;
    wire [7:0] idx;
    wire [7:0] wbyte;
    wire enable_eff;
    wire [1:0] ss_mode;
    wire ss_level;
    wire busy;
    wire done_pulse;
    wire [7:0] rx_byte;
    wire data_wr;
    wire data_ok;
    wire start;
    wire coll_set;
    wire fault_set;
    wire ovr_set;
    wire buf_load;
    wire status_wr;
    wire ctrl_wr;
    wire irq_en_wr;
    wire mask_wr;
    wire data_rd;
    wire event_rd;
    wire done_clr;
    wire coll_clr;
    wire ovr_clr;
    wire fault_clr;
    wire sclk_drv;
    wire mosi_drv;
    wire miso_drv;

    ////////////////////////////////////////////////////////////////////
    // Bus decode; one wait state, action on the edge that raises ack
    assign access = cyc_i && stb_i && !ack_o;
    assign wr = access && we_i && sel_i[0];
    assign rd = access && !we_i;
    assign idx = reg_index(adr_i);
    assign wbyte = dat_i[7:0];

    // Fault forces the port off, so it cannot fight another master
    assign enable_eff = enable_reg && !fault_reg;
    assign ss_mode = {cfg_reg, select_output_enable_reg};

    assign data_wr = wr && idx == `IDX_DATA;
    assign coll_set = data_wr && busy;
    assign data_ok = data_wr && !busy && !done_reg;
    assign start = data_ok && master_reg && enable_eff;
    assign status_wr = wr && idx == `IDX_STATUS;
    // Register selects
    assign ctrl_wr = wr && idx == `IDX_CONTROL;
    assign irq_en_wr = wr && idx == `IDX_IRQ_EN;
    assign mask_wr = wr && idx == `IDX_EVMASK;
    assign data_rd = rd && idx == `IDX_DATA;
    assign event_rd = rd && idx == `IDX_EVENT;

    // Writing zero to a flag bit clears it, one keeps it
    assign done_clr = status_wr && !wbyte[`ST_DONE];
    assign coll_clr = status_wr && !wbyte[`ST_COLL];
    assign ovr_clr = status_wr && !wbyte[`ST_OVR];
    assign fault_clr = status_wr && !wbyte[`ST_FAULT];

    // Mode fault only with the select pin as a checked input
    assign fault_set = enable_reg && master_reg &&
        ss_mode == `SS_FAULT_IN && !ss_level;
    assign ovr_set = done_pulse && unread_reg && !ovr_reg;
    assign buf_load = done_pulse && !unread_reg && !ovr_reg;

    ////////////////////////////////////////////////////////////////////
    // Serial shifter
    spi_byte_shifter #(
        .HALF_DIV(HALF_DIV)
    ) shifter (
        .clock(clock),
        .rstn(rstn),
        .enable(enable_eff),
        .master(master_reg),
        .start(start),
        .load(data_ok && !master_reg),
        .tx_byte(wbyte),
        .sclk_in(sclk_in),
        .mosi_in(mosi_in),
        .miso_in(miso_in),
        .ss_in(ss_in_n),
        .ss_level(ss_level),
        .busy(busy),
        .done(done_pulse),
        .rx_byte(rx_byte),
        .sclk_out(sclk_drv),
        .mosi_out(mosi_drv),
        .miso_out(miso_drv)
    );

    ////////////////////////////////////////////////////////////////////
    // Pins
    assign sclk_out = sclk_drv;
    assign sclk_oe = enable_eff && master_reg;
    assign mosi_out = mosi_drv;
    assign mosi_oe = enable_eff && master_reg;
    assign miso_out = miso_drv;
    assign miso_oe = enable_eff && !master_reg && !ss_level;
    // Driven select goes low while the master shifts
    assign ss_out_n = !busy;
    assign ss_oe = master_reg && ss_mode == `SS_DRIVEN;

    ////////////////////////////////////////////////////////////////////
    // Read mux
    always @* begin
        rd_next = `BYTE_RESET;
        case (idx)
            `IDX_CONTROL: begin
                rd_next[`CT_SELECT_OUTPUT_ENABLE] = select_output_enable_reg;
                rd_next[`CT_ENABLE] = enable_reg && !fault_reg;
                rd_next[`CT_MASTER] = master_reg;
            end
            `IDX_STATUS: begin
                rd_next[`ST_DONE] = done_reg;
                rd_next[`ST_COLL] = coll_reg;
                rd_next[`ST_OVR] = ovr_reg;
                rd_next[`ST_FAULT] = fault_reg;
                rd_next[`ST_CFG] = cfg_reg;
            end
            `IDX_DATA: begin
                rd_next = rx_buf_reg;
            end
            `IDX_IRQ_EN: begin
                rd_next[`IE_SERIAL] = irq_en_reg;
            end
            `IDX_EVENT: begin
                rd_next[`EV_W-1:0] = event_reg;
            end
            `IDX_EVMASK: begin
                rd_next[`EV_W-1:0] = mask_reg;
            end
            default: begin
                rd_next = `BYTE_RESET;
            end
        endcase
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= access;
            if (rd) begin
                dat_o <= {24'h000000, rd_next};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control and configuration registers
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            select_output_enable_reg <= 1'b0;
            enable_reg <= 1'b0;
            master_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            cfg_reg <= 1'b0;
            mask_reg <= {`EV_W{1'b0}};
        end else begin
            if (ctrl_wr) begin
                select_output_enable_reg <= wbyte[`CT_SELECT_OUTPUT_ENABLE];
                enable_reg <= wbyte[`CT_ENABLE];
                master_reg <= wbyte[`CT_MASTER];
            end
            if (irq_en_wr) begin
                irq_en_reg <= wbyte[`IE_SERIAL];
            end
            if (status_wr) begin
                cfg_reg <= wbyte[`ST_CFG];
            end
            if (mask_wr) begin
                mask_reg <= wbyte[`EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status flags; a hardware set wins over a software clear
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            done_reg <= 1'b0;
            coll_reg <= 1'b0;
            ovr_reg <= 1'b0;
            fault_reg <= 1'b0;
            unread_reg <= 1'b0;
            rx_buf_reg <= `BYTE_RESET;
        end else begin
            done_reg <= flag_next(done_pulse, done_reg, done_clr);
            coll_reg <= flag_next(coll_set, coll_reg, coll_clr);
            ovr_reg <= flag_next(ovr_set, ovr_reg, ovr_clr);
            fault_reg <= flag_next(fault_set, fault_reg, fault_clr);
            // A dropped byte is lost; software must read the buffer in time
            if (buf_load) begin
                rx_buf_reg <= rx_byte;
            end
            unread_reg <= buf_load ||
                (unread_reg && !data_rd);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt events, cleared by reading the event register
    always @* begin
        event_next = event_reg;
        if (event_rd) begin
            event_next = {`EV_W{1'b0}};
        end
        if (done_pulse && !done_reg) begin
            event_next[`EV_DONE] = 1'b1;
        end
        if (fault_set && !fault_reg) begin
            event_next[`EV_FAULT] = 1'b1;
        end
        if (coll_set) begin
            event_next[`EV_COLL] = 1'b1;
        end
        if (ovr_set) begin
            event_next[`EV_OVR] = 1'b1;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            event_reg <= {`EV_W{1'b0}};
        end else begin
            event_reg <= event_next;
        end
    end

    assign irq = irq_en_reg && |(event_reg & mask_reg);

endmodule
`default_nettype wire

// [dv/spi_status_and_data_regs_properties.sv]
// Pin-level checks for the serial port register block
`timescale 1ns/1ps
`default_nettype none
module spi_regs_checker #(
    parameter ADDR_W = 10,
    parameter HALF_DIV = 4
) (
    input wire logic clock, // System clock
    input wire logic rstn, // Reset, active low
    input wire logic cyc_i, // Bus cycle
    input wire logic stb_i, // Bus strobe
    input wire logic we_i, // Bus write
    input wire logic [ADDR_W-1:0] adr_i, // Bus address
    input wire logic [31:0] dat_i, // Write data
    input wire logic [3:0] sel_i, // Byte selects
    input wire logic [31:0] dat_o, // Read data
    input wire logic ack_o, // Acknowledge
    input wire logic irq, // Interrupt level
    input wire logic sclk_oe, // Clock pin drive
    input wire logic miso_oe, // Slave out drive
    input wire logic ss_in_n, // Select pin in
    input wire logic ss_oe // Select pin drive
);
    logic take;
    logic [7:0] idx;
    logic cfg_reg, select_output_enable_reg, mst_reg, ien_reg;
    logic [3:0] mask_reg;
    assign take = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
    assign idx = adr_i[9:2];
    // Shadows of written settings, so pin behaviour can be tied to them
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= 1'h0;
            select_output_enable_reg <= 1'h0;
            mst_reg <= 1'h0;
            ien_reg <= 1'h0;
            mask_reg <= 4'h0;
        end else if (take) begin
            if (idx == 8'hF4) cfg_reg <= dat_i[3];
            if (idx == 8'hF3) select_output_enable_reg <= dat_i[7];
            if (idx == 8'hF3) mst_reg <= dat_i[4];
            if (idx == 8'hF9) ien_reg <= dat_i[0];
            if (idx == 8'hE9) mask_reg <= dat_i[3:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    a_read_width:
    assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_select_usage:
    assert property (ss_oe == (mst_reg && cfg_reg && select_output_enable_reg))
        else $error("select drive does not follow settings");
    a_irq_gate:
    assert property (irq |-> ien_reg && mask_reg != 4'h0)
        else $error("interrupt while disabled");
    a_pins_exclusive:
    assert property (sclk_oe |-> mst_reg && !miso_oe)
        else $error("master drives slave output");
    a_fault_stop:
    assert property ((sclk_oe && !cfg_reg && !select_output_enable_reg && !ss_in_n) [*2]
        |-> ##[1:4] !sclk_oe)
        else $error("low select did not stop master");
    a_enable_fault:
    assert property (ack_o && !we_i && idx == 8'hF3 && dat_o[6] && dat_o[4]
        |-> sclk_oe)
        else $error("enable reads one but master halted");
    c_write: cover property (ack_o && we_i);
    c_fault: cover property ($fell(sclk_oe));
    c_irq: cover property (irq);
    c_slave: cover property (miso_oe);
endmodule
bind spi_status_and_data_regs spi_regs_checker #(
    .ADDR_W(ADDR_W), .HALF_DIV(HALF_DIV)) chk (
    .clock(clock), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
    .ack_o(ack_o), .irq(irq), .sclk_oe(sclk_oe), .miso_oe(miso_oe),
    .ss_in_n(ss_in_n), .ss_oe(ss_oe));
`default_nettype wire

// [dv/spi_far_end.sv]
// Behavioural far-end serial device, slave or master
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
    input wire logic sclk, // Resolved clock pin
    input wire logic mosi, // Resolved master out
    input wire logic miso, // Resolved master in
    input wire logic ss_n, // Resolved select
    output var logic p_sclk, // Own clock drive
    output var logic p_mosi, // Own master out
    output var logic p_miso, // Own slave out
    output var logic p_ss_n // Own select drive
);
    logic [7:0] tx, rx, sh;
    initial begin
        p_sclk = 1'h0;
        p_mosi = 1'h0;
        p_miso = 1'h0;
        p_ss_n = 1'h1;
        tx = 8'h00;
        rx = 8'h00;
        sh = 8'h00;
    end
    always @(negedge ss_n) begin
        sh = tx;
        p_miso = tx[7];
    end
    always @(posedge sclk) if (!ss_n) rx = {rx[6:0], mosi};
    always @(negedge sclk) begin
        if (!ss_n) begin
            sh = {sh[6:0], 1'h0};
            p_miso = sh[7];
        end
    end
    // Released line flips so a stale bit cannot pass for data
    always @(posedge ss_n) p_miso = ~p_miso;
    task automatic pull_select(input logic v);
        #5 p_ss_n = v;
    endtask
    // Clock stands still outside the frame
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        begin
            #5 p_ss_n = 1'h0;
            p_mosi = b[7];
            #320;
            for (int i = 0; i < 8; i++) begin
                p_sclk = 1'h1;
                r = {r[6:0], miso};
                #160 p_sclk = 1'h0;
                if (i < 7) p_mosi = b[6 - i];
                #160;
            end
            p_ss_n = 1'h1;
            p_mosi = ~p_mosi;
            #320;
        end
    endtask
endmodule
`default_nettype wire

// [dv/spi_status_and_data_regs_tb_top.sv]
// Self-checking bench for the serial port register block
`timescale 1ns/1ps
`default_nettype none
module spi_status_and_data_regs_tb_top;
    localparam [9:0] A_CT = 10'h3CC;
    localparam [9:0] A_ST = 10'h3D0;
    localparam [9:0] A_DT = 10'h3D4;
    localparam [9:0] A_IE = 10'h3E4;
    localparam [9:0] A_EV = 10'h3A0;
    localparam [9:0] A_MK = 10'h3A4;
    logic clock, rstn, cyc, stb, we;
    logic [9:0] adr;
    logic [31:0] wdat;
    logic [3:0] sel;
    logic [7:0] rd, got;
    logic [9:0] tab [7] = '{A_CT, A_ST, A_DT, A_IE, A_EV, A_MK, 10'h000};
    wire [31:0] dat_o;
    wire ack_o, irq, sclk_out, sclk_oe, mosi_out, mosi_oe;
    wire miso_out, miso_oe, ss_out_n, ss_oe;
    wire p_sclk, p_mosi, p_miso, p_ss_n;
    int n_fail, n_tests;
    wire sclk_w = sclk_oe ? sclk_out : p_sclk;
    wire mosi_w = mosi_oe ? mosi_out : p_mosi;
    wire miso_w = miso_oe ? miso_out : p_miso;
    wire ss_w = ss_oe ? ss_out_n : p_ss_n;
    spi_status_and_data_regs dut (
        .clock(clock), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(dat_o),
        .ack_o(ack_o), .irq(irq), .sclk_in(sclk_w), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
        .miso_oe(miso_oe), .ss_in_n(ss_w), .ss_out_n(ss_out_n), .ss_oe(ss_oe));
    spi_far_end far (
        .sclk(sclk_w), .mosi(mosi_w), .miso(miso_w), .ss_n(ss_w),
        .p_sclk(p_sclk), .p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        int k;
        @(posedge clock);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= 4'hF;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (ack_o !== 1'h1 && k < 20);
        rd = dat_o[7:0];
        chk({7'h0, ack_o}, 8'h01);
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask
    task automatic rchk(input logic [9:0] a, input logic [7:0] e);
        bus(1'h0, a, 8'h00);
        chk(rd, e);
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        rd = 8'h00;
        while (rd[7] !== 1'h1 && k < 100) begin
            bus(1'h0, A_ST, 8'h00);
            k++;
        end
        if (rd[7] !== 1'h1) begin
            n_fail++;
            $display("BAD %0t done flag never set", $time);
        end
    endtask
    task automatic mxfer(input logic [7:0] ftx, input logic [7:0] b);
        far.tx = ftx;
        bus(1'h1, A_DT, b);
        wait_done;
    endtask
    task automatic close_out;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end
    initial begin
        #400000;
        n_fail++;
        $display("BAD %0t timeout", $time);
        close_out;
    end
    initial begin
        rstn = 1'h0;
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        adr = 10'h000;
        wdat = 32'h0;
        sel = 4'h0;
        n_fail = 0;
        n_tests = 0;
        repeat (4) @(posedge clock);
        rstn <= 1'h1;
        foreach (tab[i]) rchk(tab[i], 8'h00);
        bus(1'h1, 10'h000, 8'hFF);
        rchk(10'h000, 8'h00);
        bus(1'h1, A_ST, 8'h08);
        rchk(A_ST, 8'h08);
        bus(1'h1, A_CT, 8'hD0);
        rchk(A_CT, 8'hD0);
        bus(1'h1, A_IE, 8'h01);
        bus(1'h1, A_MK, 8'h0F);
        mxfer(8'h3C, 8'hA5);
        rchk(A_ST, 8'h88);
        chk({7'h0, irq}, 8'h01);
        chk(far.rx, 8'hA5);
        rchk(A_DT, 8'h3C);
        rchk(A_EV, 8'h01);
        chk({7'h0, irq}, 8'h00);
        bus(1'h1, A_DT, 8'h11);
        repeat (100) @(posedge clock);
        chk(far.rx, 8'hA5);
        bus(1'h1, A_ST, 8'hF8);
        rchk(A_ST, 8'h88);
        bus(1'h1, A_ST, 8'h08);
        rchk(A_ST, 8'h08);
        far.tx = 8'h96;
        bus(1'h1, A_DT, 8'h5A);
        bus(1'h1, A_DT, 8'hFF);
        wait_done;
        rchk(A_ST, 8'hC8);
        chk(far.rx, 8'h5A);
        rchk(A_DT, 8'h96);
        rchk(A_EV, 8'h05);
        bus(1'h1, A_ST, 8'h08);
        bus(1'h1, A_MK, 8'h00);
        mxfer(8'h11, 8'h01);
        bus(1'h1, A_ST, 8'h08);
        mxfer(8'h22, 8'h02);
        rchk(A_ST, 8'hA8);
        chk({7'h0, irq}, 8'h00);
        bus(1'h1, A_MK, 8'h0F);
        chk({7'h0, irq}, 8'h01);
        rchk(A_DT, 8'h11);
        rchk(A_ST, 8'hA8);
        bus(1'h1, A_ST, 8'h28);
        rchk(A_ST, 8'h28);
        mxfer(8'h33, 8'h03);
        rchk(A_DT, 8'h11);
        bus(1'h1, A_ST, 8'h08);
        rchk(A_ST, 8'h08);
        rchk(A_EV, 8'h09);
        bus(1'h1, A_ST, 8'h00);
        bus(1'h1, A_CT, 8'h50);
        far.pull_select(1'h0);
        repeat (10) @(posedge clock);
        rchk(A_ST, 8'h10);
        rchk(A_CT, 8'h10);
        far.pull_select(1'h1);
        repeat (4) @(posedge clock);
        bus(1'h1, A_ST, 8'h00);
        rchk(A_ST, 8'h00);
        rchk(A_CT, 8'h50);
        rchk(A_EV, 8'h02);
        bus(1'h1, A_ST, 8'h08);
        far.pull_select(1'h0);
        repeat (10) @(posedge clock);
        rchk(A_ST, 8'h08);
        far.pull_select(1'h1);
        repeat (4) @(posedge clock);
        bus(1'h1, A_ST, 8'h00);
        bus(1'h1, A_CT, 8'h40);
        bus(1'h1, A_DT, 8'hC3);
        repeat (100) @(posedge clock);
        rchk(A_ST, 8'h00);
        far.xfer(8'h69, got);
        chk(got, 8'hC3);
        rchk(A_ST, 8'h80);
        rchk(A_DT, 8'h69);
        close_out;
    end
endmodule
`default_nettype wire
